// ===== hdl/chgsm_regs.sv
// Charger status and power-path mode register bank
//
// What this block does
// (RULE_01) Zone field bits 6:4, cold..hot codes
// (RULE_02) Zone reads removed 5, disabled 6
// (RULE_03) Bypass flags bits 3:0, zero when healthy
// (RULE_04) Output limit flag, 37.5ms, modes A/E/F
// (RULE_05) Output limit flag held until status read
// (RULE_06) Boost limit flag after 30ms continuous
// (RULE_07) Buck negative limit flag latched until read
// (RULE_08) Boost-on-done flag only in mode 9
// (RULE_09) Envelope bits 7:6: off, 4, 8, 16 percent
// (RULE_10) Pattern bit 5: random or linear
// (RULE_11) Removal mask bit 4 ignores removal
// (RULE_12) Modes 0-3: battery switch only
// (RULE_13) Modes 4 and 7: buck only
// (RULE_14) Mode 5: buck plus charging
// (RULE_15) Mode 6: buck to alternate target
// (RULE_16) Mode 9: boost, input switch open
// (RULE_17) Mode A: boost, input switch closed
// (RULE_18) Mode 8, B-F are reserved
// (RULE_19) Reset: no spread, random, unmasked, mode 4
// (RULE_20) Status writes ignored
`timescale 1ns/1ps
module chgsm_regs #(
  parameter int OTG_WINDOW_CYC = chgsm_pkg::OTG_WINDOW_CYC,
  parameter int BOOST_PERSIST_CYC = chgsm_pkg::BOOST_PERSIST_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Analog condition inputs (asynchronous)
  input wire logic [2:0] thermistor_temp_zone,
  input wire logic thermistor_removed,
  input wire logic thermistor_monitor_off,
  input wire logic output_switch_limit,
  input wire logic boost_limit,
  input wire logic buck_negative_limit,
  input wire logic boost_on_done,
  input wire logic charge_input_valid,
  input wire logic tracking_disable,
  // Power-path controls
  output logic battery_switch_on,
  output logic input_switch_on,
  output logic buck_en,
  output logic boost_en,
  output logic charge_en,
  output logic output_switch_en,
  output logic buck_alt_target,
  output logic [1:0] spread_envelope,
  output logic spread_pattern,
  output logic removal_detect_en,
  output logic [7:0] charge_timing
);
  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rst_s1_q;
  logic rst_s2_q;
  logic rst_l;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_l = rst_s2_q;

  // ------------------------------------------------------------
  // Input synchronisation
  // ------------------------------------------------------------
  logic [9:0] raw_in;
  logic [9:0] syn;
  logic [2:0] zone_s;
  logic removed_s;
  logic mon_off_s;
  logic otg_lim_s;
  logic bst_lim_s;
  logic bck_neg_s;
  logic swon_s;

  assign raw_in = {thermistor_temp_zone, thermistor_removed,
                   thermistor_monitor_off, output_switch_limit,
                   boost_limit, buck_negative_limit, boost_on_done,
                   charge_input_valid};

  chgsm_sync #(.WIDTH(10)) u_sync (
    .clk(mclk),
    .rst_n(rst_l),
    .d(raw_in),
    .q(syn)
  );

  assign zone_s = syn[9:7];
  assign removed_s = syn[6];
  assign mon_off_s = syn[5];
  assign otg_lim_s = syn[4];
  assign bst_lim_s = syn[3];
  assign bck_neg_s = syn[2];
  assign swon_s = syn[1];

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  logic [7:0] control_q;
  logic [7:0] timing_q;
  logic [3:0] mode;
  // Level inputs that gate the mode outputs
  logic charge_input_valid_q;
  logic tracking_q;

  assign mode = control_q[3:0];

  // Host writes to control and timing; status offset is ignored
  always_ff @(posedge mclk or negedge rst_l) begin
    if (!rst_l) begin
      control_q <= chgsm_pkg::CONTROL_RESET; // see RULE_19
      timing_q <= chgsm_pkg::TIMING_RESET;
    end else if (reg_wr) begin
      // Status offset has no write branch
      if (reg_addr == chgsm_pkg::ADDR_CONTROL) begin // see RULE_20
        control_q <= reg_wdata; // see RULE_09
      end else if (reg_addr == chgsm_pkg::ADDR_TIMING) begin
        timing_q <= reg_wdata;
      end
    end
  end

  // ------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------
  function automatic logic mode_is_otg(input logic [3:0] m);
    mode_is_otg = (m == chgsm_pkg::MODE_BOOST_OTG) ||
                  (m == chgsm_pkg::MODE_OTG_E) ||
                  (m == chgsm_pkg::MODE_OTG_F);
  endfunction : mode_is_otg

  logic m_buck;
  logic m_charge;
  logic m_buck_sys;
  logic m_boost;
  logic m_boost_otg;

  always_comb begin
    m_buck = 1'b0;
    m_charge = 1'b0;
    m_buck_sys = 1'b0;
    m_boost = 1'b0;
    m_boost_otg = 1'b0;
    // Modes 0-3 and reserved codes: every mode flag off
    case (mode) // see RULE_12 see RULE_18
      chgsm_pkg::MODE_BUCK, chgsm_pkg::MODE_BUCK_ALT: begin
        m_buck = 1'b1; // see RULE_13
      end
      chgsm_pkg::MODE_CHARGE: begin
        m_buck = 1'b1;
        m_charge = 1'b1; // see RULE_14
      end
      chgsm_pkg::MODE_BUCK_SYS: begin
        m_buck = 1'b1;
        m_buck_sys = 1'b1; // see RULE_15
      end
      chgsm_pkg::MODE_BOOST: begin
        m_boost = 1'b1; // see RULE_16
      end
      chgsm_pkg::MODE_BOOST_OTG: begin
        m_boost = 1'b1;
        m_boost_otg = 1'b1; // see RULE_17
      end
      default: begin
        m_buck = 1'b0;
      end
    endcase
  end

  // Power-path outputs, registered
  always_ff @(posedge mclk or negedge rst_l) begin
    if (!rst_l) begin
      battery_switch_on <= 1'b1;
      input_switch_on <= 1'b0;
      buck_en <= 1'b0;
      boost_en <= 1'b0;
      charge_en <= 1'b0;
      output_switch_en <= 1'b0;
      buck_alt_target <= 1'b0;
    end else begin
      battery_switch_on <= 1'b1; // see RULE_12
      buck_en <= m_buck & charge_input_valid_q;
      charge_en <= m_charge & charge_input_valid_q; // see RULE_14
      buck_alt_target <= m_buck_sys & ~tracking_q; // see RULE_15
      boost_en <= m_boost; // see RULE_16
      input_switch_on <= m_boost_otg; // see RULE_17
      output_switch_en <= m_boost_otg;
    end
  end

  // Tracking disable is a static level from the system side
  always_ff @(posedge mclk or negedge rst_l) begin
    if (!rst_l) begin
      charge_input_valid_q <= 1'b0;
      tracking_q <= 1'b0;
    end else begin
      charge_input_valid_q <= syn[0];
      tracking_q <= tracking_disable;
    end
  end

  // Spread-spectrum and mask outputs
  always_ff @(posedge mclk or negedge rst_l) begin
    if (!rst_l) begin
      spread_envelope <= 2'h0;
      spread_pattern <= 1'b0;
      removal_detect_en <= 1'b1;
      charge_timing <= chgsm_pkg::TIMING_RESET;
    end else begin
      spread_envelope <= control_q[chgsm_pkg::ENV_LSB +: 2]; // see RULE_09
      spread_pattern <= control_q[chgsm_pkg::PAT_BIT]; // see RULE_10
      removal_detect_en <= ~control_q[chgsm_pkg::MASK_BIT]; // see RULE_11
      charge_timing <= timing_q;
    end
  end

  // ------------------------------------------------------------
  // Thermistor zone
  // ------------------------------------------------------------
  logic [2:0] zone;

  always_comb begin
    if (mon_off_s) begin
      zone = chgsm_pkg::ZONE_DISABLED; // see RULE_02
    end else if (removed_s && !control_q[chgsm_pkg::MASK_BIT]) begin
      zone = chgsm_pkg::ZONE_REMOVED; // see RULE_02 see RULE_11
    end else if (zone_s > chgsm_pkg::ZONE_HOT) begin
      zone = chgsm_pkg::ZONE_HOT;
    end else begin
      zone = zone_s; // see RULE_01
    end
  end

  // ------------------------------------------------------------
  // Bypass flags
  // ------------------------------------------------------------
  logic otg_hold_done;
  logic otg_hold_run;
  logic bst_done;
  logic [3:0] bypass_q;
  logic status_read;

  assign status_read = reg_rd && (reg_addr == chgsm_pkg::ADDR_STATUS);

  // Window after the last output-limit event
  logic otg_hold_q;
  assign otg_hold_run = otg_hold_q & ~otg_lim_s;

  chgsm_timer #(.COUNT(OTG_WINDOW_CYC), .WIDTH(21)) u_otg_win (
    .clk(mclk),
    .rst_n(rst_l),
    .run(otg_hold_run),
    .done(otg_hold_done)
  );

  always_ff @(posedge mclk or negedge rst_l) begin
    if (!rst_l) begin
      otg_hold_q <= 1'b0;
    end else if (otg_lim_s && mode_is_otg(mode)) begin
      otg_hold_q <= 1'b1;
    end else if (otg_hold_done) begin
      otg_hold_q <= 1'b0;
    end
  end

  chgsm_timer #(.COUNT(BOOST_PERSIST_CYC), .WIDTH(21)) u_bst (
    .clk(mclk),
    .rst_n(rst_l),
    .run(bst_lim_s),
    .done(bst_done) // see RULE_06
  );

  // Latched bits: set wins over the read clear
  always_ff @(posedge mclk or negedge rst_l) begin
    if (!rst_l) begin
      bypass_q <= 4'h0;
    end else begin
      if (otg_hold_q && mode_is_otg(mode)) begin
        bypass_q[chgsm_pkg::BYPASS_OTG_BIT] <= 1'b1; // see RULE_04
      end else if (status_read) begin
        bypass_q[chgsm_pkg::BYPASS_OTG_BIT] <= 1'b0; // see RULE_05
      end
      bypass_q[chgsm_pkg::BYPASS_BST_BIT] <= bst_done; // see RULE_06
      if (bck_neg_s) begin
        bypass_q[chgsm_pkg::BYPASS_BCK_BIT] <= 1'b1; // see RULE_07
      end else if (status_read) begin
        bypass_q[chgsm_pkg::BYPASS_BCK_BIT] <= 1'b0; // see RULE_07
      end
      bypass_q[chgsm_pkg::BYPASS_SWON_BIT] <=
        swon_s && (mode == chgsm_pkg::MODE_BOOST); // see RULE_08
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  logic [7:0] rd_mux;

  always_comb begin
    if (reg_addr == chgsm_pkg::ADDR_STATUS) begin
      rd_mux = {1'b0, zone, bypass_q}; // see RULE_01 see RULE_03
    end else if (reg_addr == chgsm_pkg::ADDR_CONTROL) begin
      rd_mux = control_q;
    end else if (reg_addr == chgsm_pkg::ADDR_TIMING) begin
      rd_mux = timing_q;
    end else begin
      rd_mux = 8'h00;
    end
  end

  // Read data held until the next read strobe
  always_ff @(posedge mclk or negedge rst_l) begin
    if (!rst_l) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end
endmodule : chgsm_regs

// ===== hdl/chgsm_pkg.sv
// Package: offsets, fields, reset values and timing for the charger regs
package chgsm_pkg;
  // Register offsets (register index on the serial management port)
  localparam logic [7:0] ADDR_STATUS = 8'h15;
  localparam logic [7:0] ADDR_CONTROL = 8'h16;
  localparam logic [7:0] ADDR_TIMING = 8'h17;

  // Status field positions
  localparam int ZONE_LSB = 4;
  localparam int BYPASS_OTG_BIT = 0;
  localparam int BYPASS_BST_BIT = 1;
  localparam int BYPASS_BCK_BIT = 2;
  localparam int BYPASS_SWON_BIT = 3;

  // Thermistor zone codes
  localparam logic [2:0] ZONE_COLD = 3'h0;
  localparam logic [2:0] ZONE_COOL = 3'h1;
  localparam logic [2:0] ZONE_NORMAL = 3'h2;
  localparam logic [2:0] ZONE_WARM = 3'h3;
  localparam logic [2:0] ZONE_HOT = 3'h4;
  localparam logic [2:0] ZONE_REMOVED = 3'h5;
  localparam logic [2:0] ZONE_DISABLED = 3'h6;

  // Control field positions
  localparam int ENV_LSB = 6;
  localparam int PAT_BIT = 5;
  localparam int MASK_BIT = 4;

  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h04;
  localparam logic [7:0] TIMING_RESET = 8'h93;

  // Power-path mode codes
  localparam logic [3:0] MODE_BUCK = 4'h4;
  localparam logic [3:0] MODE_BUCK_ALT = 4'h7;
  localparam logic [3:0] MODE_CHARGE = 4'h5;
  localparam logic [3:0] MODE_BUCK_SYS = 4'h6;
  localparam logic [3:0] MODE_BOOST = 4'h9;
  localparam logic [3:0] MODE_BOOST_OTG = 4'hA;
  localparam logic [3:0] MODE_OTG_E = 4'hE;
  localparam logic [3:0] MODE_OTG_F = 4'hF;

  // Timing
  localparam int CLK_HZ = 20000000;
  localparam int OTG_WINDOW_US = 37500;
  localparam int BOOST_PERSIST_US = 30000;
  // Both counts truncate the clock to whole cycles per microsecond; neither rounds up
  localparam int OTG_WINDOW_CYC = (CLK_HZ / 1000000) * OTG_WINDOW_US;
  localparam int BOOST_PERSIST_CYC =
    ((CLK_HZ / 1000000) * BOOST_PERSIST_US + 0);

  typedef enum logic [1:0] {
    CHGSM_BUS_IDLE,
    CHGSM_BUS_WRITE,
    CHGSM_BUS_READ
  } chgsm_bus_t;
endpackage : chgsm_pkg

// ===== hdl/chgsm_sync.sv
// Three-stage synchroniser with second/third stage agreement
`timescale 1ns/1ps
module chgsm_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Change counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          q[i] <= s3_q[i];
        end
      end
    end
  end
endmodule : chgsm_sync

// ===== hdl/chgsm_timer.sv
// Up counter measuring a persistence or hold window
`timescale 1ns/1ps
module chgsm_timer #(
  parameter int COUNT = 16,
  parameter int WIDTH = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  output logic done
);
  logic [WIDTH-1:0] cnt_q;

  // Counts cycles while run is high, clears when it drops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      done <= 1'b0;
    end else if (!run) begin
      cnt_q <= '0;
      done <= 1'b0;
    end else if (cnt_q >= WIDTH'(COUNT - 1)) begin
      done <= 1'b1;
    end else begin
      cnt_q <= cnt_q + WIDTH'(1);
    end
  end
endmodule : chgsm_timer

// ===== verification/chgsm_host.sv
// Host model driving the register strobe port
`timescale 1ns/1ps
module chgsm_host (
  // Clock
  input wire logic mclk,
  // Register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // Idle bus shows inverted values, never the last ones
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge mclk);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge mclk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++) @(posedge mclk) #1;
    d = reg_rdata;
  endtask : rd
endmodule : chgsm_host

// ===== verification/chgsm_regs_asserts.sv
// Port checker for the charger register bank
`timescale 1ns/1ps
module chgsm_regs_asserts #(
  parameter int OTG_WINDOW_CYC = 20,
  parameter int BOOST_PERSIST_CYC = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // Power-path controls
  input wire logic battery_switch_on,
  input wire logic input_switch_on,
  input wire logic buck_en,
  input wire logic boost_en,
  input wire logic charge_en,
  input wire logic output_switch_en,
  input wire logic [1:0] spread_envelope,
  input wire logic spread_pattern,
  input wire logic removal_detect_en
);
  logic wc;
  logic [3:0] m;
  logic [3:0] f;
  assign wc = reg_wr && reg_addr == chgsm_pkg::ADDR_CONTROL;
  assign m = reg_wdata[3:0];
  assign f = reg_wdata[7:4];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_RVALID:
    assert property (reg_rvalid == $past(reg_rd)) else $error("rvalid lag");
  AST_HOLD:
    assert property (!$past(reg_rd) |-> $stable(reg_rdata))
      else $error("rdata moved without read");
  AST_UNMAPPED:
    assert property (reg_rd && (reg_addr < 8'h15 || reg_addr > 8'h17)
      |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  AST_ZONE:
    assert property (reg_rd && reg_addr == chgsm_pkg::ADDR_STATUS
      |=> !reg_rdata[7] && reg_rdata[6:4] != 3'h7) else $error("zone code");
  AST_OFF:
    assert property (wc && m < 4 |=> ##1 battery_switch_on
      && !(buck_en | boost_en | charge_en | output_switch_en))
      else $error("mode off");
  AST_BUCK:
    assert property (wc && (m == 4 || m == 7)
      |=> ##1 !(boost_en | charge_en | output_switch_en)) else $error("buck");
  AST_CHG:
    assert property (wc && m == 5 |=> ##1 !(boost_en | output_switch_en))
      else $error("charge mode");
  AST_BOOST:
    assert property (wc && m == 9 |=> ##1 boost_en && battery_switch_on
      && !(input_switch_on | buck_en | charge_en)) else $error("boost");
  AST_OTG:
    assert property (wc && m == 10 |=> ##1 boost_en && input_switch_on
      && output_switch_en && battery_switch_on) else $error("boost switch");
  AST_RSVD:
    assert property (wc && (m == 8 || m > 10)
      |=> ##1 !(boost_en | buck_en | charge_en)) else $error("reserved");
  AST_FIELDS:
    assert property (wc |=> ##1 {spread_envelope, spread_pattern,
      !removal_detect_en} == $past(f, 2)) else $error("fields");
endmodule : chgsm_regs_asserts

bind chgsm_regs chgsm_regs_asserts #(
  .OTG_WINDOW_CYC(OTG_WINDOW_CYC),
  .BOOST_PERSIST_CYC(BOOST_PERSIST_CYC)
) chk_inst (.mclk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .reg_rdata, .reg_rvalid, .battery_switch_on, .input_switch_on, .buck_en,
  .boost_en, .charge_en, .output_switch_en, .spread_envelope,
  .spread_pattern, .removal_detect_en);

// ===== verification/tb.sv
// Self-checking bench for the charger register bank
`timescale 1ns/1ps
module tb;
  logic mclk = 0;
  logic rst_n = 0;
  logic reg_wr, reg_rd, reg_rvalid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, charge_timing, v;
  logic [2:0] thermistor_temp_zone = 3'h0;
  logic thermistor_removed = 0, thermistor_monitor_off = 0;
  logic output_switch_limit = 0, boost_limit = 0, buck_negative_limit = 0;
  logic boost_on_done = 0, charge_input_valid = 0, tracking_disable = 0;
  logic battery_switch_on, input_switch_on, buck_en, boost_en, charge_en;
  logic output_switch_en, buck_alt_target, spread_pattern, removal_detect_en;
  logic [1:0] spread_envelope;
  int num_errors = 0, tests_run = 0, cyc = 0, i;
  int seed = 32'h9FF3654E;
  int ctrl = 'h04;

  chgsm_regs #(.OTG_WINDOW_CYC(20), .BOOST_PERSIST_CYC(16)) chgsm_regs_inst (
    .mclk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rvalid, .thermistor_temp_zone, .thermistor_removed,
    .thermistor_monitor_off, .output_switch_limit, .boost_limit,
    .buck_negative_limit, .boost_on_done, .charge_input_valid,
    .tracking_disable, .battery_switch_on, .input_switch_on, .buck_en,
    .boost_en, .charge_en, .output_switch_en, .buck_alt_target,
    .spread_envelope, .spread_pattern, .removal_detect_en, .charge_timing);
  chgsm_host chgsm_host_inst (.mclk, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_rvalid);

  initial forever #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (num_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string n, input logic [7:0] g, e);
    tests_run++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask : chk

  task automatic rdc(input string n, input logic [7:0] a, e);
    logic [7:0] d;
    chgsm_host_inst.rd(a, d);
    chk(n, d, e);
  endtask : rdc

  task automatic w(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : w

  // Expected status from the bench's own view of the inputs
  function automatic logic [7:0] sx(input logic [3:0] f);
    logic [2:0] z;
    z = thermistor_temp_zone > 4 ? 3'h4 : thermistor_temp_zone;
    if (thermistor_removed && !ctrl[4]) z = 3'h5;
    if (thermistor_monitor_off) z = 3'h6;
    return {1'b0, z, f};
  endfunction : sx

  task automatic st(input logic [3:0] f);
    rdc("status", chgsm_pkg::ADDR_STATUS, sx(f));
  endtask : st

  task automatic wc(input logic [7:0] d);
    chgsm_host_inst.wr(chgsm_pkg::ADDR_CONTROL, d);
    ctrl = d;
    w(8);
  endtask : wc

  initial begin
    repeat (20) @(posedge mclk);
    #1 rst_n = 1;
    w(4);
    rdc("control", chgsm_pkg::ADDR_CONTROL, 8'h04);
    rdc("timing", chgsm_pkg::ADDR_TIMING, 8'h93);
    chk("rst_outs", {battery_switch_on, removal_detect_en, spread_envelope,
      spread_pattern, boost_en, charge_en, output_switch_en},
      8'hC0);
    chk("rst_paths", {buck_en, input_switch_on, buck_alt_target},
      8'h00);
    for (i = 0; i < 16; i++) begin
      v = 8'($random(seed));
      v[3:0] = i[3:0];
      charge_input_valid = v[7];
      tracking_disable = v[6];
      wc(v);
      chk("buck", {buck_en, charge_en, buck_alt_target},
        {i / 4 == 1 && v[7], i == 5 && v[7], i == 6 && !v[6]});
      chk("boost", {boost_en, input_switch_on, output_switch_en},
        {i == 9 || i == 10, i == 10, i == 10});
      chk("spread", {spread_envelope, spread_pattern, removal_detect_en},
        {v[7:5], !v[4]});
      rdc("control", chgsm_pkg::ADDR_CONTROL, v);
      chgsm_host_inst.wr(chgsm_pkg::ADDR_TIMING, ~v);
      rdc("timing", chgsm_pkg::ADDR_TIMING, ~v);
      chk("timing_out", charge_timing, ~v);
      chgsm_host_inst.wr(8'h18 + 8'(i), v);
      rdc("unmapped", 8'h18 + 8'(i), 8'h00);
    end
    wc(8'h04);
    for (i = 0; i < 8; i++) begin
      thermistor_temp_zone = i[2:0];
      w(8);
      st(4'h0);
    end
    thermistor_removed = 1;
    w(8);
    st(4'h0);
    wc(8'h14);
    st(4'h0);
    thermistor_monitor_off = 1;
    w(8);
    st(4'h0);
    buck_negative_limit = 1;
    w(10);
    buck_negative_limit = 0;
    w(10);
    chgsm_host_inst.wr(chgsm_pkg::ADDR_STATUS, 8'h00);
    st(4'h4);
    st(4'h0);
    for (i = 9; i < 16; i++) begin
      wc({4'h1, i[3:0]});
      output_switch_limit = 1;
      w(10);
      output_switch_limit = 0;
      w(40);
      st({3'h0, i == 10 || i > 13});
      st(4'h0);
    end
    wc(8'h19);
    boost_on_done = 1;
    w(8);
    st(4'h8);
    boost_limit = 1;
    w(10);
    st(4'h8);
    w(30);
    st(4'hA);
    boost_limit = 0;
    w(10);
    st(4'h8);
    wc(8'h14);
    st(4'h0);
    stop_test();
  end
endmodule : tb
